// [rtl/remote_register_input_regs.svh]
// Constants for the remote register input block
`ifndef REMOTE_REGISTER_INPUT_REGS_SVH
`define REMOTE_REGISTER_INPUT_REGS_SVH
`define WORD_W 16
`define FREQ_MAX 16'hE678
`define PID_MAX 16'h2710
`define LAYOUT_0 8'h00
`define LAYOUT_1 8'h01
`define LAYOUT_12 8'h0C
`define LAYOUT_14 8'h0E
`define LAYOUT_18 8'h12
`define FAULT_LAST_IDX 8'h09
`define MON_ITEMS 6
`endif

// [rtl/remote_register_input_pkg.sv]
// Types for the remote register input block
package remote_register_input_pkg;
  typedef logic [15:0] word_t;
  typedef logic [7:0] byte_t;
endpackage

// [rtl/inverter_remote_register_input.sv]
// Master-to-drive remote register word interface with request/done handshakes
// What this block does
// - Word meanings hold only for layout selection 0, 1, 12, 14 or 18.
// - Monitor request latches results for monitor codes 1 and 2 into result words 0, 1.
// - Volatile request writes frequency to volatile store; nonvolatile request writes both.
// - Master loads frequency first, sets write request; drive raises matching done bit.
// - Set frequency is unsigned 0.01 Hz steps, at most 59000.
// - Instruction code in word 2 runs only once execute request rises.
// - Drive sets instruction done bit in the same cycle as the one-cycle instruction strobe.
// - Upper 8 bits of instruction word are the link extended setting field.
// - Operand word 3 is loaded with word 2 before execute request.
// - Monitor request latches results for codes 3 to 6 into result words 4 to 7.
// - Word 8 upper byte picks fault record, 00 latest to 09 tenth latest.
// - Fault index 0A to FF returns zero instead of a record.
// - Word 9 holds PID set point 0 to 100.00 percent.
// - Clearing a frequency write request clears its done bit.
// - Clearing the execute request clears the instruction done bit.
`timescale 1ns/1ns
`include "remote_register_input_regs.svh"
module inverter_remote_register_input (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire remote_register_input_pkg::byte_t layout_select_param,
  input wire remote_register_input_pkg::word_t monitor_select_1_2,
  input wire remote_register_input_pkg::word_t frequency_setpoint,
  input wire remote_register_input_pkg::word_t instruction_word,
  input wire remote_register_input_pkg::word_t instruction_operand,
  input wire remote_register_input_pkg::word_t monitor_select_3,
  input wire remote_register_input_pkg::word_t monitor_select_4,
  input wire remote_register_input_pkg::word_t monitor_select_5,
  input wire remote_register_input_pkg::word_t monitor_select_6,
  input wire remote_register_input_pkg::word_t fault_history_index,
  input wire remote_register_input_pkg::word_t pid_setpoint,
  input wire logic monitor_request_bit,
  input wire logic volatile_write_request_bit,
  input wire logic nonvolatile_write_request_bit,
  input wire logic instruction_execute_request_bit,
  input wire remote_register_input_pkg::word_t monitor_data_1,
  input wire remote_register_input_pkg::word_t monitor_data_2,
  input wire remote_register_input_pkg::word_t monitor_data_3,
  input wire remote_register_input_pkg::word_t monitor_data_4,
  input wire remote_register_input_pkg::word_t monitor_data_5,
  input wire remote_register_input_pkg::word_t monitor_data_6,
  input wire remote_register_input_pkg::word_t fault_record_data,
  output logic layout_valid,
  output remote_register_input_pkg::word_t monitor_code_12_q,
  output remote_register_input_pkg::word_t monitor_code_3456_q,
  output remote_register_input_pkg::byte_t monitor_code_sel_q,
  output remote_register_input_pkg::word_t monitor_result_word_0,
  output remote_register_input_pkg::word_t monitor_result_word_1,
  output remote_register_input_pkg::word_t monitor_result_word_4,
  output remote_register_input_pkg::word_t monitor_result_word_5,
  output remote_register_input_pkg::word_t monitor_result_word_6,
  output remote_register_input_pkg::word_t monitor_result_word_7,
  output logic monitor_done_bit,
  output remote_register_input_pkg::word_t freq_volatile_q,
  output remote_register_input_pkg::word_t freq_nonvolatile_q,
  output logic freq_range_error_q,
  output logic volatile_write_done_bit,
  output logic nonvolatile_write_done_bit,
  output remote_register_input_pkg::byte_t link_ext_setting_q,
  output remote_register_input_pkg::byte_t instruction_code_q,
  output remote_register_input_pkg::word_t instruction_data_q,
  output logic instruction_strobe_q,
  output logic instruction_done_bit,
  output remote_register_input_pkg::byte_t fault_select_q,
  output remote_register_input_pkg::word_t fault_result_q,
  output remote_register_input_pkg::word_t pid_setpoint_q,
  output logic pid_range_error_q
);
  import remote_register_input_pkg::*;

  // Done level: set by an accepted rise, held while the request stays high, cleared when it drops
  function automatic logic done_next(input logic level, input logic done_now, input logic act);
    return level && (done_now || act);
  endfunction

  // Shared range test; a word above its limit is rejected, not clamped
  function automatic logic within_max(input word_t value, input word_t limit);
    return value <= limit;
  endfunction

  // Only these layout selections give the command words their meaning
  function automatic logic layout_allowed(input byte_t sel);
    return (sel == `LAYOUT_0) || (sel == `LAYOUT_1) || (sel == `LAYOUT_12) ||
           (sel == `LAYOUT_14) || (sel == `LAYOUT_18);
  endfunction

  // Request bits arrive from the network side: three-stage sync, act when stages 2 and 3 agree
  logic [3:0] req_s1_q;
  logic [3:0] req_s2_q;
  logic [3:0] req_s3_q;
  logic [3:0] req_q;
  logic [3:0] req_raw;
  assign req_raw = {instruction_execute_request_bit, nonvolatile_write_request_bit,
                    volatile_write_request_bit, monitor_request_bit};

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      req_s1_q <= 4'h0;
      req_s2_q <= 4'h0;
      req_s3_q <= 4'h0;
    end
    else
    begin
      req_s1_q <= req_raw;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
    end
  end

  logic [3:0] agree;
  logic [3:0] req_d;
  assign agree = ~(req_s2_q ^ req_s3_q);
  assign req_d = (agree & req_s3_q) | (~agree & req_q);

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      req_q <= 4'h0;
    else
      req_q <= req_d;
  end

  logic [3:0] rise;
  assign rise = req_d & ~req_q;

  logic layout_ok;
  assign layout_ok = layout_allowed(layout_select_param);

  logic act_mon;
  logic act_vol;
  logic act_nvol;
  logic act_ins;
  assign act_mon = rise[0] && layout_ok;
  assign act_vol = rise[1] && layout_ok;
  assign act_nvol = rise[2] && layout_ok;
  assign act_ins = rise[3] && layout_ok;

  logic freq_ok;
  assign freq_ok = within_max(frequency_setpoint, `FREQ_MAX);
  logic pid_ok;
  assign pid_ok = within_max(pid_setpoint, `PID_MAX);
  byte_t fault_idx;
  assign fault_idx = fault_history_index[15:8];
  word_t fault_value;
  assign fault_value = (fault_idx > `FAULT_LAST_IDX) ? 16'h0000 : fault_record_data;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      layout_valid <= 1'b0;
      monitor_code_12_q <= 16'h0000;
      monitor_code_3456_q <= 16'h0000;
      monitor_code_sel_q <= 8'h00;
      monitor_result_word_0 <= 16'h0000;
      monitor_result_word_1 <= 16'h0000;
      monitor_result_word_4 <= 16'h0000;
      monitor_result_word_5 <= 16'h0000;
      monitor_result_word_6 <= 16'h0000;
      monitor_result_word_7 <= 16'h0000;
      monitor_done_bit <= 1'b0;
      fault_select_q <= 8'h00;
      fault_result_q <= 16'h0000;
      pid_setpoint_q <= 16'h0000;
      pid_range_error_q <= 1'b0;
    end
    else
    begin
      layout_valid <= layout_ok;
      if (act_mon)
      begin
        monitor_code_12_q <= monitor_select_1_2;
        monitor_code_3456_q <= monitor_select_3;
        monitor_code_sel_q <= {monitor_select_6[3:0], monitor_select_5[3:0]} ^ monitor_select_4[7:0];
        monitor_result_word_0 <= monitor_data_1;
        monitor_result_word_1 <= monitor_data_2;
        monitor_result_word_4 <= monitor_data_3;
        monitor_result_word_5 <= monitor_data_4;
        monitor_result_word_6 <= monitor_data_5;
        monitor_result_word_7 <= monitor_data_6;
        fault_select_q <= fault_idx;
        fault_result_q <= fault_value;
        if (pid_ok)
          pid_setpoint_q <= pid_setpoint;
        pid_range_error_q <= !pid_ok;
      end
      monitor_done_bit <= done_next(req_d[0], monitor_done_bit, act_mon);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      freq_volatile_q <= 16'h0000;
      freq_nonvolatile_q <= 16'h0000;
      freq_range_error_q <= 1'b0;
      volatile_write_done_bit <= 1'b0;
      nonvolatile_write_done_bit <= 1'b0;
    end
    else
    begin
      if ((act_vol || act_nvol) && freq_ok)
        freq_volatile_q <= frequency_setpoint;
      if (act_nvol && freq_ok)
        freq_nonvolatile_q <= frequency_setpoint;
      if (act_vol || act_nvol)
        freq_range_error_q <= !freq_ok;
      volatile_write_done_bit <= done_next(req_d[1], volatile_write_done_bit, act_vol);
      nonvolatile_write_done_bit <= done_next(req_d[2], nonvolatile_write_done_bit, act_nvol);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      link_ext_setting_q <= 8'h00;
      instruction_code_q <= 8'h00;
      instruction_data_q <= 16'h0000;
      instruction_strobe_q <= 1'b0;
      instruction_done_bit <= 1'b0;
    end
    else
    begin
      if (act_ins)
      begin
        link_ext_setting_q <= instruction_word[15:8];
        instruction_code_q <= instruction_word[7:0];
        instruction_data_q <= instruction_operand;
      end
      instruction_strobe_q <= act_ins;
      instruction_done_bit <= done_next(req_d[3], instruction_done_bit, act_ins);
    end
  end

  vol_done_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    act_vol |=> volatile_write_done_bit)
    else $error("volatile done missing");
  // A rejected value still completes the handshake, so done is checked on its own
  nvol_done_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    act_nvol |=> nonvolatile_write_done_bit && (freq_nonvolatile_q == freq_volatile_q || !$past(freq_ok)))
    else $error("nonvolatile done or copy wrong");
  mon_done_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    act_mon |=> monitor_done_bit)
    else $error("monitor done missing");

  freq_clear_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !req_d[1] |=> !volatile_write_done_bit)
    else $error("volatile done not cleared");
  nvol_clear_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !req_d[2] |=> !nonvolatile_write_done_bit)
    else $error("nonvolatile done not cleared");
  ins_clear_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !req_d[3] |=> !instruction_done_bit)
    else $error("instruction done not cleared");
  sequence ins_drop_s;
    instruction_done_bit ##1 !req_d[3];
  endsequence
  ins_drop_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    ins_drop_s |=> !instruction_done_bit)
    else $error("instruction done held after drop");

  sequence ins_launch_s;
    act_ins ##1 instruction_strobe_q;
  endsequence
  ins_done_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    ins_launch_s |-> instruction_done_bit)
    else $error("instruction done late");
  ins_field_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    act_ins |=> link_ext_setting_q == $past(instruction_word[15:8]))
    else $error("ext field wrong");
  ins_operand_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    act_ins |=> instruction_data_q == $past(instruction_operand) && instruction_code_q == $past(instruction_word[7:0]))
    else $error("instruction code or operand wrong");
  ins_once_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    instruction_strobe_q |=> !instruction_strobe_q)
    else $error("instruction ran twice");

  mon_word0_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    act_mon |=> monitor_result_word_0 == $past(monitor_data_1))
    else $error("monitor word 0 wrong");
  mon_word1_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    act_mon |=> monitor_result_word_1 == $past(monitor_data_2))
    else $error("monitor word 1 wrong");
  mon_word7_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    act_mon |=> monitor_result_word_7 == $past(monitor_data_6))
    else $error("monitor word 7 wrong");
  mon_code_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    act_mon |=> monitor_code_3456_q == $past(monitor_select_3))
    else $error("monitor code 3 wrong");
  fault_zero_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    act_mon && fault_idx > `FAULT_LAST_IDX |=> fault_result_q == 16'h0000)
    else $error("fault not zero");
  fault_pass_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    act_mon && fault_idx <= `FAULT_LAST_IDX |=> fault_result_q == $past(fault_record_data))
    else $error("fault record not passed");

  freq_max_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    freq_volatile_q <= `FREQ_MAX)
    else $error("frequency above maximum");
  freq_reject_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (act_vol || act_nvol) && !freq_ok |=> $stable(freq_volatile_q) && freq_range_error_q)
    else $error("out of range frequency taken");
  pid_max_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    pid_setpoint_q <= `PID_MAX)
    else $error("set point above maximum");

  // stores move only on an accepted rise, layout_valid follows the layout every cycle; words may change freely meanwhile
  layout_gate_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !layout_ok && rise[3] |=> !instruction_strobe_q)
    else $error("ran under bad layout");
  layout_valid_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    1'b1 |=> layout_valid == $past(layout_ok))
    else $error("layout flag wrong");
  freq_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !(act_vol || act_nvol) |=> $stable(freq_volatile_q))
    else $error("frequency moved without request");
  mon_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !act_mon |=> $stable(monitor_code_12_q))
    else $error("monitor code moved without request");
endmodule

// [sim/master_model.sv]
// Network master model: command words and request handshakes
`timescale 1ns/1ns
module master_model (
  input wire logic core_clk,
  input wire logic [3:0] done,
  output remote_register_input_pkg::word_t w [10],
  output logic [3:0] req
);
  import remote_register_input_pkg::*;
  initial
  begin
    req = 4'h0;
    foreach (w[i]) w[i] = 16'h0000;
  end
  // words are loaded before the request
  task automatic load(input int i, input word_t v);
    @(posedge core_clk);
    w[i] <= v;
  endtask
  // hold until done, drop, then wait for done low
  task automatic request(input int i, output logic ok);
    int n;
    repeat ($urandom_range(0, 3)) @(posedge core_clk);
    @(posedge core_clk);
    req[i] <= 1'b1;
    for (n = 0; n < 12 && done[i] !== 1'b1; n++)
      @(negedge core_clk);
    ok = done[i];
    @(posedge core_clk);
    req[i] <= 1'b0;
    for (n = 0; n < 12 && done[i] !== 1'b0; n++)
      @(negedge core_clk);
    // Let the synchroniser see the low level before any re-arm
    repeat (4) @(posedge core_clk);
  endtask
endmodule

// [sim/tb.sv]
// Self-checking bench for the remote register input block
`timescale 1ns/1ns
module tb;
  import remote_register_input_pkg::*;
  logic core_clk, reset_n, layout_valid, monitor_done_bit, volatile_write_done_bit, nonvolatile_write_done_bit;
  logic freq_range_error_q, instruction_strobe_q, instruction_done_bit, pid_range_error_q, ok;
  byte_t layout_select_param, monitor_code_sel_q, link_ext_setting_q, instruction_code_q, fault_select_q;
  word_t monitor_code_12_q, monitor_code_3456_q, monitor_result_word_0, monitor_result_word_1;
  word_t monitor_result_word_4, monitor_result_word_5, monitor_result_word_6, monitor_result_word_7;
  word_t freq_volatile_q, freq_nonvolatile_q, instruction_data_q, fault_result_q, pid_setpoint_q;
  word_t w [10];
  word_t dw [7];
  logic [3:0] req;
  int n_mismatch = 0, checks = 0, strobes = 0, exp_v = 0, exp_nv = 0, v, k, c;
  int lay [5] = '{0, 1, 12, 14, 18};
  int fidx [$] = '{0, 9, 10, 255, 3};
  int md [7];
  int mc [4];
  int p, exp_pid = 0;
  master_model master_model_inst (.core_clk(core_clk), .w(w), .req(req),
    .done({instruction_done_bit, nonvolatile_write_done_bit, volatile_write_done_bit, monitor_done_bit}));
  inverter_remote_register_input inverter_remote_register_input_inst (.*, .monitor_select_1_2(w[0]),
    .frequency_setpoint(w[1]), .instruction_word(w[2]), .instruction_operand(w[3]), .monitor_select_3(w[4]),
    .monitor_select_4(w[5]), .monitor_select_5(w[6]), .monitor_select_6(w[7]), .fault_history_index(w[8]),
    .pid_setpoint(w[9]), .monitor_request_bit(req[0]), .volatile_write_request_bit(req[1]),
    .nonvolatile_write_request_bit(req[2]), .instruction_execute_request_bit(req[3]),
    .monitor_data_1(dw[0]), .monitor_data_2(dw[1]), .monitor_data_3(dw[2]), .monitor_data_4(dw[3]),
    .monitor_data_5(dw[4]), .monitor_data_6(dw[5]), .fault_record_data(dw[6]));
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
    if (instruction_strobe_q === 1'b1) strobes++;
  task automatic cmp(input string what, input word_t e, input word_t g);
    checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic final_report();
    $display("Counts: %0d checks, %0d mismatches", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #300000;
    n_mismatch++;
    final_report();
  end
  initial
  begin
    reset_n = 1'b0;
    layout_select_param = 8'h00;
    foreach (dw[i]) dw[i] = 16'h0000;
    v = $urandom(6113);
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    for (k = 0; k < 5; k++)
    begin
      @(posedge core_clk);
      layout_select_param <= byte_t'(lay[k]);
      foreach (md[i]) md[i] = $urandom_range(0, 65535);
      foreach (md[i]) dw[i] <= word_t'(md[i]);
      c = $urandom_range(0, 65535);
      master_model_inst.load(0, word_t'(c));
      // lower byte of the fault index is always zero
      master_model_inst.load(8, {byte_t'(fidx[k]), 8'h00});
      foreach (mc[i])
      begin
        mc[i] = $urandom_range(0, 65535);
        master_model_inst.load(4 + i, word_t'(mc[i]));
      end
      // one pass puts the set point above 100.00 percent, which must be refused
      p = (k == 3) ? 10001 : $urandom_range(0, 10000);
      master_model_inst.load(9, word_t'(p));
      if (p <= 10000) exp_pid = p;
      v = (((mc[3] & 15) << 4) | (mc[2] & 15)) ^ (mc[1] & 255);
      master_model_inst.request(0, ok);
      cmp("layout_valid", 16'h0001, {15'h0, layout_valid});
      cmp("monitor_done", 16'h0001, {15'h0, ok});
      cmp("monitor_code_12", word_t'(c), monitor_code_12_q);
      cmp("monitor_result_0", word_t'(md[0]), monitor_result_word_0);
      cmp("monitor_result_1", word_t'(md[1]), monitor_result_word_1);
      cmp("monitor_result_4", word_t'(md[2]), monitor_result_word_4);
      cmp("monitor_result_5", word_t'(md[3]), monitor_result_word_5);
      cmp("monitor_result_6", word_t'(md[4]), monitor_result_word_6);
      cmp("monitor_result_7", word_t'(md[5]), monitor_result_word_7);
      cmp("monitor_code_3456", word_t'(mc[0]), monitor_code_3456_q);
      cmp("monitor_code_sel", word_t'(v), {8'h00, monitor_code_sel_q});
      cmp("pid_setpoint", word_t'(exp_pid), pid_setpoint_q);
      cmp("pid_error", {15'h0, p > 10000}, {15'h0, pid_range_error_q});
      cmp("fault_select", word_t'(fidx[k]), {8'h00, fault_select_q});
      cmp("fault_result", (fidx[k] <= 9) ? word_t'(md[6]) : 16'h0000, fault_result_q);
    end
    $display("monitor test done");
    for (k = 0; k < 6; k++)
    begin
      v = (k < 2) ? $urandom_range(0, 59000) : 58999 + k / 2;
      master_model_inst.load(1, word_t'(v));
      master_model_inst.request(1 + k % 2, ok);
      if (v <= 59000) exp_v = v;
      if (v <= 59000 && k % 2 == 1) exp_nv = v;
      cmp("write_done", 16'h0001, {15'h0, ok});
      cmp("write_done_clear", 16'h0000, {15'h0, volatile_write_done_bit | nonvolatile_write_done_bit});
      cmp("freq_volatile", word_t'(exp_v), freq_volatile_q);
      cmp("freq_nonvolatile", word_t'(exp_nv), freq_nonvolatile_q);
      cmp("freq_error", {15'h0, v > 59000}, {15'h0, freq_range_error_q});
    end
    master_model_inst.load(1, 16'h1234);
    repeat (8) @(posedge core_clk);
    cmp("freq_no_rearm", word_t'(exp_v), freq_volatile_q);
    $display("frequency test done");
    for (k = 0; k < 3; k++)
    begin
      v = $urandom_range(0, 65535);
      c = (k == 1) ? 0 : $urandom_range(1, 65535);
      master_model_inst.load(2, word_t'(v));
      // the middle pass carries no operand, so zero is sent
      master_model_inst.load(3, word_t'(c));
      strobes = 0;
      master_model_inst.request(3, ok);
      cmp("instr_done", 16'h0001, {15'h0, ok});
      cmp("instr_strobes", 16'h0001, word_t'(strobes));
      cmp("link_ext", word_t'(v >> 8), {8'h00, link_ext_setting_q});
      cmp("instr_code", word_t'(v & 255), {8'h00, instruction_code_q});
      cmp("instr_operand", word_t'(c), instruction_data_q);
      cmp("instr_done_clear", 16'h0000, {15'h0, instruction_done_bit});
    end
    $display("instruction test done");
    @(posedge core_clk);
    layout_select_param <= 8'h02;
    strobes = 0;
    master_model_inst.request(3, ok);
    cmp("bad_layout_done", 16'h0000, {15'h0, ok});
    cmp("bad_layout_strobes", 16'h0000, word_t'(strobes));
    cmp("bad_layout_valid", 16'h0000, {15'h0, layout_valid});
    $display("layout test done");
    final_report();
  end
endmodule
